//--- common/trip_init_pkg.sv
// Constants and types shared by the trip-point and register-initialisation logic
package trip_init_pkg;
    // Register map, bank 1 (working registers)
    localparam logic [7:0] BANK1_FIRST_OFS = 8'h20;
    localparam logic [7:0] BANK1_LAST_OFS = 8'h7F;
    localparam int BANK1_BYTES = 96;
    localparam logic [7:0] I_POS_TRIP_OFS = 8'h60;
    localparam logic [7:0] I_NEG_TRIP_OFS = 8'h64;
    localparam logic [7:0] PACK_EXIT_TRIP_OFS = 8'h68;
    localparam logic [7:0] CHARGE_TRIP_OFS = 8'h6C;
    localparam logic [7:0] SHELF_TRIP_OFS = 8'h70;
    localparam logic [7:0] SLEEP_TRIP_CONTROL_OFS = 8'h76;
    // Register map, bank 2 (calibration and setup)
    localparam logic [7:0] BANK2_FIRST_OFS = 8'h80;
    localparam logic [7:0] BANK2_LAST_OFS = 8'h87;
    localparam int BANK2_BYTES = 8;
    localparam logic [7:0] BUS_SLAVE_ADDRESS_OFS = 8'h80;
    localparam logic [7:0] BANDGAP_TRIM_OFS = 8'h81;
    localparam logic [7:0] REFERENCE_TRIM_OFS = 8'h82;
    localparam logic [7:0] MAIN_OSC_TRIM_OFS = 8'h83;
    localparam logic [7:0] CLOCK_TEST_SELECT_OFS = 8'h84;
    localparam logic [7:0] TEST_SIGNAL_SELECT_OFS = 8'h85;
    localparam logic [7:0] AUX_OSC_TRIM_OFS = 8'h86;
    // Bank codes on the register port
    localparam logic [1:0] BANK_WORKING = 2'h1;
    localparam logic [1:0] BANK_SETUP = 2'h2;
    // Values before the nonvolatile load completes
    localparam logic [7:0] WORKING_RESET = 8'h00;
    localparam logic [7:0] BUS_SLAVE_ADDRESS_RESET = 8'h26;
    localparam logic [7:0] SETUP_RESET = 8'h00;
    // Nonvolatile range copied at power-on
    localparam logic [7:0] LOAD_FIRST_ADDR = 8'h20;
    localparam logic [7:0] LOAD_LAST_ADDR = 8'h87;
    // Sleep trip control fields
    localparam int CURRENT_EXIT_EN_BIT = 7;
    localparam int CURRENT_ENTRY_EN_BIT = 6;
    localparam int PACK_VOLT_EXIT_EN_BIT = 5;
    localparam int PACK_VOLT_ENTRY_EN_BIT = 4;
    localparam int AUX_INPUT_ENTRY_EN_BIT = 3;
    localparam int SHELF_ENTRY_EN_BIT = 2;
    localparam int TRIP_RESERVED_BIT = 1;
    localparam int OVERFLOW_BIT = 0;
    localparam logic [7:0] TRIP_WRITABLE_MASK = 8'hFC;
    // Sign-magnitude, left justified: sign on top, magnitude below
    localparam int MAG_BITS = 15;
    // Loader buffer
    localparam int LOAD_FIFO_DEPTH = 32;
    localparam int LOAD_WORD_BITS = 16;

    typedef enum logic [3:0] {
        LD_ISSUE = 4'b0001,
        LD_WAIT = 4'b0010,
        LD_FLUSH = 4'b0100,
        LD_DONE = 4'b1000
    } load_state_t;
endpackage : trip_init_pkg

//--- common/load_stream_if.sv
// Valid/ready stream between the loader and its buffer
`timescale 1ns/100ps
`default_nettype none
interface load_stream_if #(parameter int WIDTH = 16);
    logic push_valid;
    logic push_ready;
    logic [WIDTH-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [WIDTH-1:0] pop_data;
    modport buffer (input push_valid, push_data, pop_ready,
                    output push_ready, pop_valid, pop_data);
    modport user (output push_valid, push_data, pop_ready,
                  input push_ready, pop_valid, pop_data);
endinterface : load_stream_if
`default_nettype wire

//--- hw/load_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module load_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Stream
    load_stream_if.buffer s
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
    } fifo_state_t;

    fifo_state_t cur_reg;
    fifo_state_t cur_next;
    logic full;
    logic empty;

    assign full = (cur_reg.wr_ptr[AW] != cur_reg.rd_ptr[AW])
               && (cur_reg.wr_ptr[AW-1:0] == cur_reg.rd_ptr[AW-1:0]);
    assign empty = cur_reg.wr_ptr == cur_reg.rd_ptr;
    assign s.push_ready = !full;
    assign s.pop_valid = !empty;
    assign s.pop_data = cur_reg.mem[cur_reg.rd_ptr[AW-1:0]];

    always_comb begin
        cur_next = cur_reg;
        if (s.push_valid && !full) begin
            cur_next.mem[cur_reg.wr_ptr[AW-1:0]] = s.push_data;
            cur_next.wr_ptr = cur_reg.wr_ptr + 1'b1;
        end
        if (s.pop_ready && !empty) begin
            cur_next.rd_ptr = cur_reg.rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end
endmodule : load_fifo
`default_nettype wire

//--- hw/sleep_trip_and_eeprom_init.sv
// Sleep trip-point detection and power-on register load from nonvolatile memory
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// RULE1 - Current exit enabled: leave sample-sleep when current magnitude exceeds positive threshold.
// RULE2 - Current entry enabled: enter sample-sleep when current magnitude is below negative threshold.
// RULE3 - Pack exit enabled: leave sample-sleep when pack voltage exceeds pack exit threshold.
// RULE4 - Pack entry enabled: enter sample-sleep when pack voltage is below charge threshold.
// RULE5 - Software enables pack entry only when the auxiliary analog input is grounded.
// RULE6 - Power-on reset loads every register from nonvolatile locations 0x020 to 0x087.
// RULE7 - Nonvolatile 0x020 to 0x07F copy into the same bank 1 addresses.
// RULE8 - Nonvolatile 0x080 to 0x087 copy into the same bank 2 setup addresses.
// RULE9 - Nonvolatile images of reserved registers must hold zero.
// RULE10 - Factory image leaves accumulators, timers, conversions and converter registers zeroed.
// RULE11 - Factory image disables sleep modes and entries, zeroes thresholds, disables GPIO mode.
// RULE12 - Bus slave address lives at setup 0x80, default 0x26.
// RULE13 - Clock test and test multiplexer registers default to zero.
// RULE14 - Software leaves the factory trims and other critical defaults unchanged.
// RULE15 - Trip comparisons use magnitudes only and ignore the sign bit.
// RULE16 - Aux entry compares aux result to charge threshold; shelf entry compares pack to shelf.
// RULE17 - Overflow flag sets when a converter input is out of range, readable by software.
module sleep_trip_and_eeprom_init
    import trip_init_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Nonvolatile memory read port (bank 0)
    output logic [7:0] ee_addr,
    output logic ee_rd,
    input wire logic [7:0] ee_rdata,
    input wire logic ee_ack,
    // Register port
    input wire logic [1:0] reg_bank,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Converter results
    input wire logic conv_valid,
    input wire logic [15:0] current_result,
    input wire logic [15:0] pack_volt_result,
    input wire logic [15:0] aux_input_result,
    input wire logic adc_overrange,
    // Status and setup outputs
    output logic load_done,
    output logic sample_sleep_active,
    output logic sleep_enter_pulse,
    output logic sleep_exit_pulse,
    output logic shelf_entry_pulse,
    output logic [7:0] bus_slave_address,
    output logic [7:0] clock_test_select,
    output logic [7:0] test_signal_select
);
    typedef struct packed {
        load_state_t st;
        logic [7:0] ee_addr;
        logic ee_rd;
        logic [BANK1_BYTES-1:0][7:0] bank1;
        logic [BANK2_BYTES-1:0][7:0] bank2;
        logic sleep;
        logic enter_p;
        logic exit_p;
        logic shelf_p;
        logic [7:0] rdata;
    } core_state_t;

    core_state_t cur_reg;
    core_state_t cur_next;

    load_stream_if #(.WIDTH(LOAD_WORD_BITS)) ld ();

    load_fifo #(.WIDTH(LOAD_WORD_BITS), .DEPTH(LOAD_FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .s(ld.buffer)
    );

    function automatic logic [6:0] b1_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - BANK1_FIRST_OFS;
        return d[6:0];
    endfunction : b1_idx

    function automatic logic [MAG_BITS-1:0] mag(input logic [15:0] v);
        return v[MAG_BITS-1:0];
    endfunction : mag

    logic [7:0] trip;
    logic [15:0] i_pos_thr;
    logic [15:0] i_neg_thr;
    logic [15:0] pack_exit_threshold;
    logic [15:0] charge_volt_threshold;
    logic [15:0] shelf_threshold;
    logic done;
    logic pop_fire;
    logic [7:0] pop_addr;
    logic [7:0] pop_byte;
    logic exit_hit;
    logic enter_hit;
    logic shelf_hit;

    assign trip = cur_reg.bank1[b1_idx(SLEEP_TRIP_CONTROL_OFS)];
    assign i_pos_thr = {cur_reg.bank1[b1_idx(I_POS_TRIP_OFS) + 7'h01],
                        cur_reg.bank1[b1_idx(I_POS_TRIP_OFS)]};
    assign i_neg_thr = {cur_reg.bank1[b1_idx(I_NEG_TRIP_OFS) + 7'h01],
                        cur_reg.bank1[b1_idx(I_NEG_TRIP_OFS)]};
    assign pack_exit_threshold = {cur_reg.bank1[b1_idx(PACK_EXIT_TRIP_OFS) + 7'h01],
                                  cur_reg.bank1[b1_idx(PACK_EXIT_TRIP_OFS)]};
    assign charge_volt_threshold = {cur_reg.bank1[b1_idx(CHARGE_TRIP_OFS) + 7'h01],
                                    cur_reg.bank1[b1_idx(CHARGE_TRIP_OFS)]};
    assign shelf_threshold = {cur_reg.bank1[b1_idx(SHELF_TRIP_OFS) + 7'h01],
                              cur_reg.bank1[b1_idx(SHELF_TRIP_OFS)]};
    assign done = cur_reg.st == LD_DONE;

    // Software writes take the register file first; the drain stalls and the buffer fills
    assign ld.pop_ready = !reg_wr;
    assign pop_fire = ld.pop_valid && ld.pop_ready;
    assign pop_addr = ld.pop_data[15:8];
    assign pop_byte = ld.pop_data[7:0];
    assign ld.push_valid = (cur_reg.st == LD_WAIT) && ee_ack;
    assign ld.push_data = {cur_reg.ee_addr, ee_rdata};

    // Trips are only judged on a fresh result once the working registers are valid
    always_comb begin
        exit_hit = 1'b0;
        enter_hit = 1'b0;
        shelf_hit = 1'b0;
        if (conv_valid && done) begin
            if (trip[CURRENT_EXIT_EN_BIT]
                && mag(current_result) > mag(i_pos_thr)) begin // see RULE1 see RULE15
                exit_hit = 1'b1;
            end
            if (trip[PACK_VOLT_EXIT_EN_BIT]
                && mag(pack_volt_result) > mag(pack_exit_threshold)) begin // see RULE3
                exit_hit = 1'b1;
            end
            if (trip[CURRENT_ENTRY_EN_BIT]
                && mag(current_result) < mag(i_neg_thr)) begin // see RULE2
                enter_hit = 1'b1;
            end
            if (trip[PACK_VOLT_ENTRY_EN_BIT]
                && mag(pack_volt_result) < mag(charge_volt_threshold)) begin // see RULE4
                enter_hit = 1'b1;
            end
            if (trip[AUX_INPUT_ENTRY_EN_BIT]
                && mag(aux_input_result) < mag(charge_volt_threshold)) begin // see RULE16
                enter_hit = 1'b1;
            end
            if (trip[SHELF_ENTRY_EN_BIT]
                && mag(pack_volt_result) < mag(shelf_threshold)) begin // see RULE16
                shelf_hit = 1'b1;
            end
        end
    end

    always_comb begin
        cur_next = cur_reg;
        cur_next.ee_rd = 1'b0;
        cur_next.enter_p = 1'b0;
        cur_next.exit_p = 1'b0;
        cur_next.shelf_p = 1'b0;

        // Loader: one outstanding read, issued only while the buffer has room
        unique case (cur_reg.st)
            LD_ISSUE: begin
                if (ld.push_ready) begin // see RULE6
                    cur_next.ee_rd = 1'b1;
                    cur_next.st = LD_WAIT;
                end
            end
            LD_WAIT: begin
                if (ee_ack) begin
                    if (cur_reg.ee_addr == LOAD_LAST_ADDR) begin // see RULE6
                        cur_next.st = LD_FLUSH;
                    end else begin
                        cur_next.ee_addr = cur_reg.ee_addr + 8'h01;
                        cur_next.st = LD_ISSUE;
                    end
                end
            end
            LD_FLUSH: begin
                if (!ld.pop_valid) begin
                    cur_next.st = LD_DONE;
                end
            end
            LD_DONE: begin
            end
        endcase

        // Drain: the image lands at the same address in bank 1 or bank 2
        if (pop_fire) begin
            if (pop_addr <= BANK1_LAST_OFS) begin // see RULE7 see RULE10 see RULE11
                cur_next.bank1[b1_idx(pop_addr)] = pop_byte;
            end else begin // see RULE8 see RULE12 see RULE13
                cur_next.bank2[pop_addr[2:0]] = pop_byte;
            end
        end

        // Software writes; unmapped addresses are ignored
        if (reg_wr) begin
            if (reg_bank == BANK_WORKING && reg_addr >= BANK1_FIRST_OFS
                && reg_addr <= BANK1_LAST_OFS) begin
                cur_next.bank1[b1_idx(reg_addr)] = reg_wdata;
                // Software may clear the overflow flag but never raise it
                if (reg_addr == SLEEP_TRIP_CONTROL_OFS) begin // see RULE17
                    cur_next.bank1[b1_idx(reg_addr)] = (reg_wdata & TRIP_WRITABLE_MASK)
                        | (reg_wdata & cur_reg.bank1[b1_idx(reg_addr)] & ~TRIP_WRITABLE_MASK);
                end
            end else if (reg_bank == BANK_SETUP && reg_addr >= BANK2_FIRST_OFS
                && reg_addr <= BANK2_LAST_OFS) begin
                cur_next.bank2[reg_addr[2:0]] = reg_wdata;
            end
        end

        // Reserved bit stays zero; overflow is cleared by writing zero, but a new event wins
        cur_next.bank1[b1_idx(SLEEP_TRIP_CONTROL_OFS)][TRIP_RESERVED_BIT] = 1'b0;
        if (adc_overrange) begin
            cur_next.bank1[b1_idx(SLEEP_TRIP_CONTROL_OFS)][OVERFLOW_BIT] = 1'b1; // see RULE17
        end

        // Waking has priority when entry and exit trip on the same result
        if (exit_hit && cur_reg.sleep) begin // see RULE1 see RULE3
            cur_next.sleep = 1'b0;
            cur_next.exit_p = 1'b1;
        end else if (enter_hit && !exit_hit && !cur_reg.sleep) begin // see RULE2 see RULE4
            cur_next.sleep = 1'b1;
            cur_next.enter_p = 1'b1;
        end
        cur_next.shelf_p = shelf_hit; // see RULE16

        // Read data registered one cycle after the strobe; unmapped reads return zero
        if (reg_rd) begin
            cur_next.rdata = 8'h00;
            if (reg_bank == BANK_WORKING && reg_addr >= BANK1_FIRST_OFS
                && reg_addr <= BANK1_LAST_OFS) begin
                cur_next.rdata = cur_reg.bank1[b1_idx(reg_addr)];
            end else if (reg_bank == BANK_SETUP && reg_addr >= BANK2_FIRST_OFS
                && reg_addr <= BANK2_LAST_OFS) begin
                cur_next.rdata = cur_reg.bank2[reg_addr[2:0]];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_reg.st <= LD_ISSUE;
            cur_reg.ee_addr <= LOAD_FIRST_ADDR;
            cur_reg.ee_rd <= 1'b0;
            cur_reg.bank1 <= {BANK1_BYTES{WORKING_RESET}};
            cur_reg.bank2 <= {{7{SETUP_RESET}}, BUS_SLAVE_ADDRESS_RESET}; // see RULE12
            cur_reg.sleep <= 1'b0;
            cur_reg.enter_p <= 1'b0;
            cur_reg.exit_p <= 1'b0;
            cur_reg.shelf_p <= 1'b0;
            cur_reg.rdata <= 8'h00;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign ee_addr = cur_reg.ee_addr;
    assign ee_rd = cur_reg.ee_rd;
    assign reg_rdata = cur_reg.rdata;
    assign load_done = done;
    assign sample_sleep_active = cur_reg.sleep;
    assign sleep_enter_pulse = cur_reg.enter_p;
    assign sleep_exit_pulse = cur_reg.exit_p;
    assign shelf_entry_pulse = cur_reg.shelf_p;
    assign bus_slave_address = cur_reg.bank2[BUS_SLAVE_ADDRESS_OFS[2:0]];
    assign clock_test_select = cur_reg.bank2[CLOCK_TEST_SELECT_OFS[2:0]];
    assign test_signal_select = cur_reg.bank2[TEST_SIGNAL_SELECT_OFS[2:0]];

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    logic up_reg;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            up_reg <= 1'b0;
        end else begin
            up_reg <= 1'b1;
        end
    end

    property p_current_exit;
        conv_valid && done && cur_reg.sleep && trip[CURRENT_EXIT_EN_BIT]
            && mag(current_result) > mag(i_pos_thr)
            |=> sleep_exit_pulse && !sample_sleep_active;
    endproperty
    a_current_exit: assert property (p_current_exit) else $error("current exit missed"); // see RULE1

    property p_current_entry;
        conv_valid && done && !cur_reg.sleep && !exit_hit && trip[CURRENT_ENTRY_EN_BIT]
            && mag(current_result) < mag(i_neg_thr)
            |=> sleep_enter_pulse && sample_sleep_active;
    endproperty
    a_current_entry: assert property (p_current_entry) else $error("current entry missed"); // see RULE2

    property p_pack_exit;
        conv_valid && done && cur_reg.sleep && trip[PACK_VOLT_EXIT_EN_BIT]
            && mag(pack_volt_result) > mag(pack_exit_threshold) |=> !sample_sleep_active;
    endproperty
    a_pack_exit: assert property (p_pack_exit) else $error("pack exit missed"); // see RULE3

    property p_pack_entry;
        conv_valid && done && !cur_reg.sleep && !exit_hit && trip[PACK_VOLT_ENTRY_EN_BIT]
            && mag(pack_volt_result) < mag(charge_volt_threshold) |=> $rose(sample_sleep_active);
    endproperty
    a_pack_entry: assert property (p_pack_entry) else $error("pack entry missed"); // see RULE4

    property p_load_walk;
        $rose(load_done) |-> $past(ee_addr) == LOAD_LAST_ADDR && !ld.pop_valid;
    endproperty
    a_load_walk: assert property (p_load_walk) else $error("load ended early"); // see RULE6

    property p_bank1_copy;
        logic [7:0] a;
        logic [7:0] d;
        (pop_fire && pop_addr <= BANK1_LAST_OFS && pop_addr != SLEEP_TRIP_CONTROL_OFS,
            a = pop_addr, d = pop_byte)
            |=> reg_wr || cur_reg.bank1[b1_idx(a)] == d;
    endproperty
    a_bank1_copy: assert property (p_bank1_copy) else $error("bank 1 copy wrong"); // see RULE7

    property p_bank2_copy;
        logic [7:0] a;
        logic [7:0] d;
        (pop_fire && pop_addr >= BANK2_FIRST_OFS, a = pop_addr, d = pop_byte)
            |=> reg_wr || cur_reg.bank2[a[2:0]] == d;
    endproperty
    a_bank2_copy: assert property (p_bank2_copy) else $error("bank 2 copy wrong"); // see RULE8

    property p_setup_defaults;
        $rose(up_reg) |-> bus_slave_address == BUS_SLAVE_ADDRESS_RESET
            && clock_test_select == SETUP_RESET && test_signal_select == SETUP_RESET;
    endproperty
    a_setup_defaults: assert property (p_setup_defaults) else $error("setup default wrong"); // see RULE12 see RULE13

    property p_overflow;
        adc_overrange |=> trip[OVERFLOW_BIT] ##0 !trip[TRIP_RESERVED_BIT];
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not flagged"); // see RULE17

    property p_shelf;
        conv_valid && done && trip[SHELF_ENTRY_EN_BIT]
            && mag(pack_volt_result) < mag(shelf_threshold) |=> shelf_entry_pulse;
    endproperty
    a_shelf: assert property (p_shelf) else $error("shelf entry missed"); // see RULE16

    property p_cov_load;
        $rose(load_done);
    endproperty
    c_cov_load: cover property (p_cov_load);

    property p_cov_sleep_cycle;
        sleep_enter_pulse ##[1:200] sleep_exit_pulse;
    endproperty
    c_cov_sleep_cycle: cover property (p_cov_sleep_cycle);

    property p_cov_backpressure;
        !ld.push_ready && reg_wr;
    endproperty
    c_cov_backpressure: cover property (p_cov_backpressure);
endmodule : sleep_trip_and_eeprom_init
`default_nettype wire

//--- bench/ee_image_model.sv
// Nonvolatile memory model answering the loader's byte reads
`timescale 1ns/100ps
`default_nettype none
module ee_image_model (
    // Clock
    input wire logic ref_clk,
    // Read port
    input wire logic [7:0] ee_addr,
    input wire logic ee_rd,
    output logic [7:0] ee_rdata,
    output logic ee_ack,
    // Answer delay in cycles, at least 1
    input wire logic [3:0] ack_delay
);
    logic [7:0] a;
    function automatic logic [7:0] image(input logic [7:0] x);
        if (x < 8'h60) return x ^ 8'hA5;
        if (x == 8'h80) return 8'h26;
        if (x inside {8'h81, 8'h82, 8'h83, 8'h86}) return x + 8'h30;
        return 8'h00;
    endfunction : image
    initial begin
        ee_ack = 1'b0;
        ee_rdata = 8'hFF;
        forever begin
            @(posedge ref_clk);
            if (ee_rd === 1'b1) begin
                a = ee_addr;
                repeat (int'(ack_delay) - 1) @(posedge ref_clk);
                ee_ack <= 1'b1;
                ee_rdata <= image(a);
                @(posedge ref_clk);
                ee_ack <= 1'b0;
                // Released data never keeps the last byte
                ee_rdata <= ~image(a);
            end
        end
    end
endmodule : ee_image_model
`default_nettype wire

//--- bench/test_sleep_trip_and_eeprom_init.sv
// Self-checking bench for trip detection and power-on register load
`timescale 1ns/100ps
`default_nettype none
module test_sleep_trip_and_eeprom_init;
    import trip_init_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] ee_addr, ee_rdata, reg_rdata, rd_val, bsa, cts, tss;
    logic ee_rd, ee_ack, load_done, ssa, sep, sxp, shp;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    logic [1:0] reg_bank = 2'h1;
    logic reg_wr = 1'b0, reg_rd = 1'b0, conv_valid = 1'b0, adc_overrange = 1'b0;
    logic [15:0] cur = 16'h0000, vp = 16'h0000, aux = 16'h0000;
    logic [3:0] ack_delay = 4'h1;
    int mismatches = 0, checks_done = 0;

    always #50 ref_clk = ~ref_clk;

    sleep_trip_and_eeprom_init uut (.ref_clk(ref_clk), .rst_b(rst_b), .ee_addr(ee_addr),
        .ee_rd(ee_rd), .ee_rdata(ee_rdata), .ee_ack(ee_ack), .reg_bank(reg_bank),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .conv_valid(conv_valid), .current_result(cur),
        .pack_volt_result(vp), .aux_input_result(aux), .adc_overrange(adc_overrange),
        .load_done(load_done), .sample_sleep_active(ssa), .sleep_enter_pulse(sep),
        .sleep_exit_pulse(sxp), .shelf_entry_pulse(shp), .bus_slave_address(bsa),
        .clock_test_select(cts), .test_signal_select(tss));
    ee_image_model eeprom (.ref_clk(ref_clk), .ee_addr(ee_addr), .ee_rd(ee_rd),
        .ee_rdata(ee_rdata), .ee_ack(ee_ack), .ack_delay(ack_delay));

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    task automatic reg_write(input logic [1:0] b, input logic [7:0] ad, input logic [7:0] d);
        @(negedge ref_clk);
        reg_bank = b;
        reg_addr = ad;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [1:0] b, input logic [7:0] ad);
        @(negedge ref_clk);
        reg_bank = b;
        reg_addr = ad;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        rd_val = reg_rdata;
    endtask : reg_read

    task automatic load_and_compare();
        int i;
        for (i = 0; i < 3000 && load_done !== 1'b1; i++) @(negedge ref_clk);
        check("load done", load_done, 1'b1);
        for (i = 32; i < 136; i++) begin
            reg_read(i < 128 ? BANK_WORKING : BANK_SETUP, i[7:0]);
            check("register image", rd_val, eeprom.image(i[7:0]));
        end
        check("setup outputs", {bsa, cts, tss}, 24'h260000);
    endtask : load_and_compare

    task automatic t_load();
        repeat (8) @(negedge ref_clk);
        check("reset outputs", {ee_rd, load_done, bsa}, 10'h026);
        rst_b = 1'b1;
        load_and_compare();
        reg_read(BANK_SETUP, 8'h20);
        check("unmapped read", rd_val, 8'h00);
        $display("test load finished");
    endtask : t_load

    task automatic t_reload();
        reg_write(BANK_WORKING, BANK1_FIRST_OFS, 8'h00);
        reg_write(BANK_SETUP, CLOCK_TEST_SELECT_OFS, 8'h5A);
        check("clock test select", cts, 8'h5A);
        // Slow memory this time, so the buffer sees a different rhythm
        ack_delay = 4'h4;
        rst_b = 1'b0;
        repeat (3) @(negedge ref_clk);
        rst_b = 1'b1;
        load_and_compare();
        $display("test reload finished");
    endtask : t_reload

    task automatic trip(input logic [7:0] c, input logic [15:0] i, input logic [15:0] p,
                        input logic [15:0] x, input logic [3:0] exp);
        reg_write(BANK_WORKING, SLEEP_TRIP_CONTROL_OFS, c);
        @(negedge ref_clk);
        cur = i;
        vp = p;
        aux = x;
        conv_valid = 1'b1;
        @(negedge ref_clk);
        conv_valid = 1'b0;
        check("trip outputs", {sep, sxp, shp, ssa}, exp);
        @(negedge ref_clk);
        check("pulse width", {sep, sxp, shp}, 3'b000);
    endtask : trip

    task automatic t_trips();
        reg_write(BANK_WORKING, I_POS_TRIP_OFS, 8'h00);
        reg_write(BANK_WORKING, I_POS_TRIP_OFS + 8'h01, 8'h02);
        reg_write(BANK_WORKING, I_NEG_TRIP_OFS, 8'h00);
        reg_write(BANK_WORKING, I_NEG_TRIP_OFS + 8'h01, 8'h81);
        reg_write(BANK_WORKING, PACK_EXIT_TRIP_OFS + 8'h01, 8'h04);
        reg_write(BANK_WORKING, CHARGE_TRIP_OFS + 8'h01, 8'h03);
        reg_write(BANK_WORKING, SHELF_TRIP_OFS + 8'h01, 8'h05);
        trip(8'h40, 16'h80FF, 16'h0000, 16'h0000, 4'b1001);
        trip(8'h40, 16'h0050, 16'h0000, 16'h0000, 4'b0001);
        trip(8'h80, 16'h8201, 16'h0000, 16'h0000, 4'b0100);
        trip(8'h10, 16'h0000, 16'h02FF, 16'h0000, 4'b1001);
        trip(8'h20, 16'h0000, 16'h0401, 16'h0000, 4'b0100);
        trip(8'h08, 16'h0000, 16'h0000, 16'h0300, 4'b0000);
        trip(8'h08, 16'h0000, 16'h0000, 16'h82FF, 4'b1001);
        trip(8'h80, 16'h0200, 16'h0000, 16'h0000, 4'b0001);
        trip(8'h04, 16'h0000, 16'h04FF, 16'h0000, 4'b0011);
        $display("test trips finished");
    endtask : t_trips

    task automatic t_overflow();
        reg_write(BANK_WORKING, SLEEP_TRIP_CONTROL_OFS, 8'hFF);
        reg_read(BANK_WORKING, SLEEP_TRIP_CONTROL_OFS);
        check("trip control", rd_val, 8'hFC);
        @(negedge ref_clk);
        adc_overrange = 1'b1;
        @(negedge ref_clk);
        adc_overrange = 1'b0;
        reg_read(BANK_WORKING, SLEEP_TRIP_CONTROL_OFS);
        check("overflow set", rd_val, 8'hFD);
        reg_write(BANK_WORKING, SLEEP_TRIP_CONTROL_OFS, 8'h00);
        reg_read(BANK_WORKING, SLEEP_TRIP_CONTROL_OFS);
        check("overflow cleared", rd_val, 8'h00);
        $display("test overflow finished");
    endtask : t_overflow

    initial begin
        t_load();
        t_reload();
        t_trips();
        t_overflow();
        final_report();
    end

    // Whole run needs under two thousand cycles
    initial begin
        repeat (30000) @(posedge ref_clk);
        mismatches++;
        $display("watchdog expired");
        final_report();
    end
endmodule : test_sleep_trip_and_eeprom_init
`default_nettype wire
